/* File: purs_power_up_reset_sequencer.v */
// Power-up reset sequencer: supply monitor gating, clock defaults, boot
//
// Overview of operation
// R1: Both supply monitors enabled at power-up
// R2: Hold system reset until both supplies good
// R3: Select system RC oscillator once power stable
// R4: Fuses choose whether monitors stay enabled
// R5: All PLLs disabled at start-up
// R6: All module clocks running, undivided at start
// R7: CPU fetch starts at 0x8000_0000 after release
// R8: Software may later set PLLs, dividers, gates
// R9: Software switches off 3.3V regulator if single
// R10: External party holds reset pin low if slow
// R11: Software should keep I/O monitor active
// R12: Reset release synchronised to RC clock
`timescale 1ns/1ps
`include "purs_defines.vh"
module purs_power_up_reset_sequencer (
	input wire clk_sys_in,
	input wire rstn_in,
	input wire io_supply_good_in,
	input wire core_supply_good_in,
	input wire fuse_io_monitor_keep_in,
	input wire fuse_core_monitor_keep_in,
	input wire [`PURS_NUM_PLL-1:0] sw_pll_enable_in,
	input wire [`PURS_NUM_MOD-1:0] sw_clock_gate_in,
	input wire [`PURS_NUM_MOD*`PURS_DIV_W-1:0] sw_clock_div_in,
	input wire sw_cfg_write_in,
	output reg io_supply_monitor_en_out,
	output reg core_supply_monitor_en_out,
	output reg system_reset_n_out,
	output reg clk_src_rc_out,
	output reg [`PURS_NUM_PLL-1:0] pll_enable_out,
	output reg [`PURS_NUM_MOD-1:0] module_clock_en_out,
	output reg [`PURS_NUM_MOD*`PURS_DIV_W-1:0] module_clock_div_out,
	output reg [31:0] cpu_fetch_addr_out,
	output reg cpu_fetch_start_out
);
	localparam ST_POWER = 3'b001;
	localparam ST_SETTLE = 3'b010;
	localparam ST_RUN = 3'b100;
	// Settle count taken from the header, cut to the counter width on purpose
	localparam integer SETTLE_INT = `PURS_SETTLE_CYC;
	localparam [`PURS_CNT_W-1:0] SETTLE_CYC = SETTLE_INT[`PURS_CNT_W-1:0];

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [`PURS_CNT_W-1:0] cnt_ff;
	reg [`PURS_CNT_W-1:0] nxt_cnt;
	reg io_meta_ff;
	reg io_sync_ff;
	reg core_meta_ff;
	reg core_sync_ff;
	reg fio_meta_ff;
	reg fio_sync_ff;
	reg fcore_meta_ff;
	reg fcore_sync_ff;
	wire supplies_ok;

	// Two-flop synchronisers for supply and fuse levels
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			io_meta_ff <= 1'b0;
			io_sync_ff <= 1'b0;
			core_meta_ff <= 1'b0;
			core_sync_ff <= 1'b0;
			fio_meta_ff <= 1'b1;
			fio_sync_ff <= 1'b1;
			fcore_meta_ff <= 1'b1;
			fcore_sync_ff <= 1'b1;
		end else begin
			io_meta_ff <= io_supply_good_in;
			io_sync_ff <= io_meta_ff;
			core_meta_ff <= core_supply_good_in;
			core_sync_ff <= core_meta_ff;
			fio_meta_ff <= fuse_io_monitor_keep_in;
			fio_sync_ff <= fio_meta_ff;
			fcore_meta_ff <= fuse_core_monitor_keep_in;
			fcore_sync_ff <= fcore_meta_ff;
		end
	end

	// Both monitors must report good before leaving reset
	assign supplies_ok = io_sync_ff & core_sync_ff; // [R2]

	// Sequencing state machine
	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_POWER: begin
				nxt_cnt = {`PURS_CNT_W{1'b0}};
				if (supplies_ok) begin
					nxt_state = ST_SETTLE; // [R2]
				end
			end
			ST_SETTLE: begin
				if (!supplies_ok) begin
					nxt_state = ST_POWER;
				end else if (cnt_ff == SETTLE_CYC - 1'b1) begin
					nxt_state = ST_RUN; // [R12]
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			ST_RUN: begin
				if (!supplies_ok) begin
					nxt_state = ST_POWER; // [R2]
				end
			end
			default: begin
				nxt_state = ST_POWER;
			end
		endcase
	end

	// State, reset output and monitor enables
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff <= ST_POWER;
			cnt_ff <= {`PURS_CNT_W{1'b0}};
			system_reset_n_out <= 1'b0;
			io_supply_monitor_en_out <= 1'b1; // [R1]
			core_supply_monitor_en_out <= 1'b1; // [R1]
			clk_src_rc_out <= 1'b1; // [R3]
			cpu_fetch_addr_out <= `PURS_RESET_VECTOR;
			cpu_fetch_start_out <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			// Single clocked release so all modules leave reset together
			system_reset_n_out <= (nxt_state == ST_RUN); // [R12]
			cpu_fetch_start_out <= (nxt_state == ST_RUN) &&
				(state_ff != ST_RUN); // [R7]
			cpu_fetch_addr_out <= `PURS_RESET_VECTOR; // [R7]
			clk_src_rc_out <= 1'b1; // [R3]
			// Follow the fuses only while released, so reset never sees them off
			if (nxt_state == ST_RUN) begin
				io_supply_monitor_en_out <= fio_sync_ff; // [R4]
				core_supply_monitor_en_out <= fcore_sync_ff; // [R4]
			end else begin
				io_supply_monitor_en_out <= 1'b1; // [R1]
				core_supply_monitor_en_out <= 1'b1; // [R1]
			end
		end
	end

	// Clock defaults held in reset; software settings taken while running
	always @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pll_enable_out <= {`PURS_NUM_PLL{1'b0}}; // [R5]
			module_clock_en_out <= {`PURS_NUM_MOD{1'b1}}; // [R6]
			module_clock_div_out <= {`PURS_NUM_MOD{`PURS_DIV_UNDIVIDED}};
		end else if (state_ff != ST_RUN) begin
			pll_enable_out <= {`PURS_NUM_PLL{1'b0}}; // [R5]
			module_clock_en_out <= {`PURS_NUM_MOD{1'b1}}; // [R6]
			module_clock_div_out <= {`PURS_NUM_MOD{`PURS_DIV_UNDIVIDED}};
		end else if (sw_cfg_write_in) begin
			pll_enable_out <= sw_pll_enable_in; // [R8]
			module_clock_en_out <= sw_clock_gate_in; // [R8]
			module_clock_div_out <= sw_clock_div_in; // [R8]
		end
	end
endmodule

/* File: purs_defines.vh */
// Constants for the power-up reset sequencer
`ifndef PURS_DEFINES_VH
`define PURS_DEFINES_VH
`define PURS_RESET_VECTOR 32'h8000_0000
`define PURS_RC_FREQ_KHZ 115
`define PURS_CLK_PERIOD_NS 5
`define PURS_SETTLE_NS 100
`define PURS_SETTLE_CYC ((`PURS_SETTLE_NS + `PURS_CLK_PERIOD_NS - 1) / `PURS_CLK_PERIOD_NS)
`define PURS_CNT_W 5
`define PURS_NUM_PLL 2
`define PURS_NUM_MOD 8
`define PURS_DIV_W 4
`define PURS_DIV_UNDIVIDED 4'h0
`endif

/* File: purs_supply_model.sv */
// Supplies and external reset driver model
`timescale 1ns/1ps
module purs_supply_model (input wire logic clk_in, hold_in, up_in,
	output logic rstn_out, output logic io_out = 0, core_out = 0);
	// Pin low while held; core supply rises a cycle after the I/O supply, both drop together
	assign rstn_out = !hold_in;
	always @(negedge clk_in) {io_out, core_out} <= {up_in, io_out & up_in};
endmodule

/* File: purs_assertions.sv */
// Port checker for the power-up reset sequencer
`timescale 1ns/1ps
module purs_assertions (
	input wire clk_sys_in, rstn_in, io_supply_good_in, core_supply_good_in,
	input wire fuse_io_monitor_keep_in, io_supply_monitor_en_out,
	input wire core_supply_monitor_en_out, system_reset_n_out, clk_src_rc_out,
	input wire [1:0] pll_enable_out,
	input wire [7:0] module_clock_en_out,
	input wire [31:0] module_clock_div_out, cpu_fetch_addr_out,
	input wire cpu_fetch_start_out);
	// Release edge, with a one-cycle fetch pulse starting in the same cycle
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	sequence s_up; $rose(system_reset_n_out); endsequence
	sequence s_go; cpu_fetch_start_out ##1 !cpu_fetch_start_out; endsequence
	AST_MON: assert property (!system_reset_n_out |->
		io_supply_monitor_en_out && core_supply_monitor_en_out) else $error("mon");
	AST_DROP: assert property ($fell(io_supply_good_in) |->
		##[1:4] !system_reset_n_out) else $error("drop");
	AST_EARLY: assert property (s_up |-> $past(io_supply_good_in, 3) &&
		$past(core_supply_good_in, 3)) else $error("early");
	AST_RC: assert property (clk_src_rc_out) else $error("rc");
	AST_FUSE: assert property (system_reset_n_out [*4] |->
		io_supply_monitor_en_out == fuse_io_monitor_keep_in) else $error("fuse");
	AST_PLL: assert property (s_up |-> pll_enable_out == 2'h0)
		else $error("pll");
	AST_CLK: assert property (s_up |-> &module_clock_en_out &&
		module_clock_div_out == 32'h0) else $error("clk");
	AST_GO: assert property (s_up |->
		cpu_fetch_addr_out == 32'h8000_0000 ##0 s_go) else $error("go");
endmodule
bind purs_power_up_reset_sequencer purs_assertions chk (.*);

/* File: testbench.sv */
// Self-checking bench for the power-up reset sequencer
`timescale 1ns/1ps
module testbench;
	logic clk_sys_in = 0, hold = 1, up = 0, sw_cfg_write_in = 0;
	logic fuse_io_monitor_keep_in, fuse_core_monitor_keep_in;
	logic [1:0] sw_pll_enable_in = 0;
	logic [7:0] sw_clock_gate_in = 0;
	logic [31:0] sw_clock_div_in = 0;
	logic [74:0] q[$], last, cur, dv = {3'h4, 8'hff, 32'h0, 32'h8000_0000};
	wire rstn_in, io_supply_good_in, core_supply_good_in, clk_src_rc_out;
	wire io_supply_monitor_en_out, core_supply_monitor_en_out;
	wire system_reset_n_out, cpu_fetch_start_out;
	wire [1:0] pll_enable_out;
	wire [7:0] module_clock_en_out;
	wire [31:0] module_clock_div_out, cpu_fetch_addr_out;
	integer seed = 79773, failures = 0, checked = 0, i, r;
	assign cur = {clk_src_rc_out, pll_enable_out, module_clock_en_out,
		module_clock_div_out, cpu_fetch_addr_out};
	// Clock, supply model and design
	always #2.5 clk_sys_in = ~clk_sys_in;
	purs_supply_model pm (.clk_in(clk_sys_in), .hold_in(hold), .up_in(up),
		.rstn_out(rstn_in), .io_out(io_supply_good_in),
		.core_out(core_supply_good_in));
	purs_power_up_reset_sequencer uut (.*);
	task chk(input logic [74:0] got, exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task finish_test;
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Oldest note compared when outputs change or boot starts
	always @(negedge clk_sys_in) begin
		if (rstn_in && (cpu_fetch_start_out || cur !== last) && q.size() > 0)
			chk(cur, q.pop_front());
		if (rstn_in && cpu_fetch_start_out)
			chk({system_reset_n_out, io_supply_monitor_en_out,
				core_supply_monitor_en_out}, {1'b1, fuse_io_monitor_keep_in,
				fuse_core_monitor_keep_in});
		if (rstn_in && !system_reset_n_out)
			chk({io_supply_monitor_en_out, core_supply_monitor_en_out},
				2'h3);
		last = cur;
	end
	// Hang guard
	initial begin
		#5000;
		failures++;
		finish_test;
	end
	// Two rounds of power-up, back-to-back writes, supply loss, refused write, power-up again
	initial begin
		for (r = 0; r < 2; r++) begin
			hold = 1;
			{fuse_io_monitor_keep_in, fuse_core_monitor_keep_in} = 2'($random(seed));
			up = 0;
			repeat (10) @(negedge clk_sys_in);
			hold = 0;
			q.push_back(dv);
			up = 1;
			wait (q.size() == 0);
			for (i = 0; i < 4; i++) begin
				@(negedge clk_sys_in);
				sw_cfg_write_in = i < 3;
				sw_pll_enable_in = sw_pll_enable_in ^ 2'h1;
				sw_clock_gate_in = 8'($random(seed));
				sw_clock_div_in = $random(seed);
				if (i < 3) q.push_back({1'h1, sw_pll_enable_in, sw_clock_gate_in,
					sw_clock_div_in, 32'h8000_0000});
			end
			wait (q.size() == 0);
			q.push_back(dv);
			up = 0;
			wait (q.size() == 0);
			repeat (3) @(negedge clk_sys_in);
			sw_cfg_write_in = 1;
			@(negedge clk_sys_in);
			sw_cfg_write_in = 0;
			q.push_back(dv);
			up = 1;
			wait (q.size() == 0);
			repeat (8) @(negedge clk_sys_in);
		end
		finish_test;
	end
endmodule
